// File: logic/signal_check_pkg.sv
package signal_check_pkg;

    // ==================================================================
    // register indices and byte addresses (byte address = 4 x index)
    localparam logic [7:0] IDX_MONITOR_SELECT = 8'h30;
    localparam logic [7:0] IDX_WAKEUP_TIMEOUT = 8'h31;
    localparam logic [7:0] IDX_SLICER_LOW = 8'h32;
    localparam logic [7:0] IDX_SLICER_HIGH = 8'h33;
    localparam logic [7:0] IDX_TIMING_CHECK = 8'h34;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h38;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h39;
    localparam logic [7:0] IDX_MONITOR_STATUS = 8'h3A;
    localparam logic [7:0] ADDR_MONITOR_SELECT = {IDX_MONITOR_SELECT[5:0], 2'h0};
    localparam logic [7:0] ADDR_WAKEUP_TIMEOUT = {IDX_WAKEUP_TIMEOUT[5:0], 2'h0};
    localparam logic [7:0] ADDR_SLICER_LOW = {IDX_SLICER_LOW[5:0], 2'h0};
    localparam logic [7:0] ADDR_SLICER_HIGH = {IDX_SLICER_HIGH[5:0], 2'h0};
    localparam logic [7:0] ADDR_TIMING_CHECK = {IDX_TIMING_CHECK[5:0], 2'h0};
    localparam logic [7:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[5:0], 2'h0};
    localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'h0};
    localparam logic [7:0] ADDR_MONITOR_STATUS = {IDX_MONITOR_STATUS[5:0], 2'h0};

    // ==================================================================
    // field positions
    localparam int MON_EN_LSB = 1;
    localparam int MON_EN_W = 6;
    localparam int MON_ACCU_BIT = 0;
    localparam int TO_PRESC_LSB = 6;
    localparam int TO_COUNT_W = 6;
    localparam int TC_OBS_LSB = 5;
    localparam int TC_SUM_LSB = 2;
    localparam int TC_SGL_LSB = 0;
    localparam int IRQ_EOF = 0;
    localparam int IRQ_TIMEOUT = 1;
    localparam int IRQ_SLICER = 2;
    localparam int IRQ_W = 3;

    // ==================================================================
    // reset values
    localparam logic [7:0] RST_MONITOR_SELECT = 8'h00;
    localparam logic [7:0] RST_WAKEUP_TIMEOUT = 8'h00;
    localparam logic [7:0] RST_SLICER_LOW = 8'h00;
    localparam logic [7:0] RST_SLICER_HIGH = 8'h00;
    localparam logic [6:0] RST_TIMING_CHECK = 7'h00;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;

    // ==================================================================
    // timing tables: tick in bit periods, limits in chip/128 units
    localparam logic [6:0] TICK_DIV [4] = '{7'h02, 7'h04, 7'h10, 7'h40};
    localparam logic [5:0] OBS_BITS [4] = '{6'h08, 6'h10, 6'h18, 6'h20};
    localparam logic [7:0] SUM_LIMIT [8] = '{8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'hC0};
    localparam logic [7:0] SGL_LIMIT [4] = '{8'h10, 8'h18, 8'h20, 8'h30};
    localparam logic [2:0] GROUP_LAST = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==================================================================
    // types
    typedef struct packed {
        logic [1:0] obsCode;
        logic [2:0] sumCode;
        logic [1:0] sglCode;
    } timing_cfg_type;

    typedef enum logic {TIMER_IDLE, TIMER_RUN} timer_state_type;

    typedef struct packed {
        logic signed [12:0] groupSum;
        logic [2:0] groupBits;
        logic [5:0] observed;
        logic intervalReject;
        logic baudFail;
    } checker_state_type;

    typedef struct packed {
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [7:0] wData;
        logic wLane;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [7:0] rData;
        logic [1:0] rResp;
        logic [5:0] monEnable;
        logic accumulate;
        logic [7:0] timeoutReg;
        logic [7:0] slicerLow;
        logic [7:0] slicerHigh;
        timing_cfg_type timingCfg;
        logic [IRQ_W-1:0] irqStatus;
        logic [IRQ_W-1:0] irqMask;
        logic [5:0] errAccum;
        timer_state_type timerState;
        logic [5:0] prescCount;
        logic [5:0] tickCount;
        logic timeoutPulse;
    } regs_state_type;

endpackage : signal_check_pkg

// File: logic/timing_checker.sv
`timescale 1ns/1ps
module timing_checker
    import signal_check_pkg::*;
(
    input wire logic clk,
    input wire logic rstSync_n,
    input timing_cfg_type cfg,
    input wire logic start,
    input wire logic active,
    input wire logic bitTick,
    input wire logic intervalValid,
    input wire logic signed [8:0] intervalError,
    output logic intervalReject,
    output logic baudFail
);

    checker_state_type st;
    checker_state_type next_st;
    logic [8:0] absErr;
    logic [12:0] absSum;
    logic signed [12:0] addend;
    logic [8:0] sglLimit;
    logic [12:0] sumLimit;
    logic [5:0] obsLen;

    // ==================================================================
    // magnitudes; -(-256) still fits as an unsigned 9-bit value
    assign absErr = intervalError[8] ? 9'(-intervalError) : intervalError;
    assign absSum = st.groupSum[12] ? 13'(-st.groupSum) : st.groupSum;
    assign addend = intervalValid ? {{4{intervalError[8]}}, intervalError} : 13'sh0000;
    assign sglLimit = {1'b0, SGL_LIMIT[cfg.sglCode]};
    assign sumLimit = {5'h00, SUM_LIMIT[cfg.sumCode]};
    assign obsLen = OBS_BITS[cfg.obsCode];
    assign intervalReject = st.intervalReject;
    assign baudFail = st.baudFail;

    // next state; signed errors cancel inside a group, so drift shows, jitter not
    always_comb
    begin
        next_st = st;
        next_st.intervalReject = 1'b0;
        next_st.baudFail = 1'b0;
        if (start)
        begin
            next_st.groupSum = 13'sh0000;
            next_st.groupBits = 3'h0;
            next_st.observed = 6'h00;
        end
        else if (active)
        begin
            next_st.intervalReject = intervalValid && !(absErr < sglLimit); // [R15] [R16]
            next_st.groupSum = st.groupSum + addend;
            if (bitTick && st.observed < obsLen) // [R13]
            begin
                next_st.observed = st.observed + 6'h01;
                next_st.groupBits = st.groupBits + 3'h1;
                if (st.groupBits == GROUP_LAST)
                begin
                    next_st.baudFail = absSum > sumLimit; // [R14] [R17]
                    next_st.groupSum = addend;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            st <= '0;
        else
            st <= next_st;
    end

    a_single_accept: assert property (@(posedge clk) disable iff (!rstSync_n) // [R15]
        active && !start && intervalValid && absErr < sglLimit |=> !intervalReject)
        else $error("interval within limit was rejected");

    a_single_reject: assert property (@(posedge clk) disable iff (!rstSync_n) // [R16]
        active && !start && intervalValid && absErr >= sglLimit |=> intervalReject)
        else $error("interval at or above limit was accepted");

    a_baud_group: assert property (@(posedge clk) disable iff (!rstSync_n) // [R17]
        active && !start && bitTick && st.observed < obsLen && st.groupBits == GROUP_LAST
        |=> baudFail == $past(absSum > sumLimit))
        else $error("baud group result wrong");

    a_observe_end: assert property (@(posedge clk) disable iff (!rstSync_n) // [R13]
        st.observed >= obsLen && !start |=> !baudFail)
        else $error("baud check past observation length");

endmodule : timing_checker

// File: logic/signal_check_config_regs.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - six enable bits choose which monitors may judge data reception
// R2 - enable bits 6 to 1: chip timeout, chip timing, coding, baud, RSSI, amplitude
// R3 - any enabled monitor error during reception raises the end-of-frame flag
// R4 - accumulate bit set collects errors over the whole reception
// R5 - accumulator clears at reception start and when status is sampled
// R6 - nonzero timeout count ends wakeup search after count times tick period
// R7 - timeout count zero disables the timer entirely
// R8 - prescaler codes pick tick of 2, 4, 16 or 64 bit periods
// R9 - low threshold register holds acquired slicer threshold low bits
// R10 - high threshold register holds acquired slicer threshold high bits
// R11 - threshold registers accept writes so software can restore a saved value
// R12 - stored initial threshold is never presented as the working threshold
// R13 - baud observation code picks 8, 16, 24 or 32 observed bits
// R14 - summed threshold code picks per-8-bit error limit 16 to 192
// R15 - single interval accepted only when its absolute error is below limit
// R16 - single interval limit code picks 16, 24, 32 or 48
// R17 - baud check fails when an 8-bit group error sum exceeds limit
// R18 - software writes zero to reserved bits and ignores their read value
module signal_check_config_regs
    import signal_check_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic dataRxStart,
    input wire logic dataRxActive,
    input wire logic bitTick,
    input wire logic chipTimeoutError,
    input wire logic codingError,
    input wire logic rssiError,
    input wire logic amplitudeError,
    input wire logic intervalValid,
    input wire logic signed [8:0] intervalError,
    input wire logic wakeupSearchStart,
    input wire logic wakeupSearchActive,
    input wire logic slicerAcquireValid,
    input wire logic [15:0] slicerAcquired,
    output logic endOfFrame,
    output logic wakeupTimeout,
    output logic [15:0] slicerInitialThreshold,
    output logic irq
);

    // ==================================================================
    // reset release
    logic [1:0] rstPipe;
    logic rstSync_n;

    // asynchronous assert, synchronous release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstPipe <= 2'h0;
        else
            rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstSync_n = rstPipe[1];

    // ==================================================================
    // state and derived signals
    regs_state_type st;
    regs_state_type next_st;
    logic chipReject;
    logic baudFail;
    logic [5:0] rawErr;
    logic [5:0] errs;
    logic doWrite;
    logic wrHit;
    logic rdHit;
    logic [7:0] rdMux;
    logic sampleRead;
    logic clearAcc;
    logic [5:0] accBase;
    logic [6:0] tickDiv;
    logic [5:0] toCount;
    logic [12:0] helperBits;

    // bit order follows the enable field, chip timeout on top
    assign rawErr = {chipTimeoutError, chipReject, codingError, baudFail, rssiError, amplitudeError}; // [R2]
    assign errs = rawErr & st.monEnable & {6{dataRxActive}}; // [R1]
    assign tickDiv = TICK_DIV[st.timeoutReg[TO_PRESC_LSB +: 2]]; // [R8]
    assign toCount = st.timeoutReg[TO_COUNT_W-1:0];
    assign doWrite = st.awHeld && st.wHeld && !st.bValid;

    // ==================================================================
    // checkers for chip interval and baud rate
    timing_checker timingUnit
    (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .cfg(st.timingCfg),
        .start(dataRxStart),
        .active(dataRxActive),
        .bitTick(bitTick),
        .intervalValid(intervalValid),
        .intervalError(intervalError),
        .intervalReject(chipReject),
        .baudFail(baudFail)
    );

    // ==================================================================
    // bus handshake outputs; a channel reopens once its response is taken
    assign awready = !st.awHeld && !st.bValid;
    assign wready = !st.wHeld && !st.bValid;
    assign arready = !st.rValid;
    assign bvalid = st.bValid;
    assign bresp = st.bResp;
    assign rvalid = st.rValid;
    assign rdata = {24'h000000, st.rData};
    assign rresp = st.rResp;
    assign endOfFrame = st.irqStatus[IRQ_EOF]; // [R3]
    assign wakeupTimeout = st.timeoutPulse;
    // only the captured initial value leaves here, never the live threshold
    assign slicerInitialThreshold = {st.slicerHigh, st.slicerLow}; // [R12]
    assign irq = |(st.irqStatus & st.irqMask);

    // read decode; reserved bits read as zero
    always_comb
    begin
        rdHit = 1'b1;
        rdMux = 8'h00;
        unique case (araddr)
            ADDR_MONITOR_SELECT: rdMux = {1'b0, st.monEnable, st.accumulate};
            ADDR_WAKEUP_TIMEOUT: rdMux = st.timeoutReg;
            ADDR_SLICER_LOW: rdMux = st.slicerLow; // [R9]
            ADDR_SLICER_HIGH: rdMux = st.slicerHigh; // [R10]
            ADDR_TIMING_CHECK: rdMux = {1'b0, st.timingCfg};
            ADDR_IRQ_STATUS: rdMux = {5'h00, st.irqStatus};
            ADDR_IRQ_MASK: rdMux = {5'h00, st.irqMask};
            ADDR_MONITOR_STATUS: rdMux = {2'h0, st.errAccum};
            default: rdHit = 1'b0;
        endcase
    end

    // write decode against the held address
    always_comb
    begin
        unique case (st.awAddr)
            ADDR_MONITOR_SELECT, ADDR_WAKEUP_TIMEOUT, ADDR_SLICER_LOW, ADDR_SLICER_HIGH,
            ADDR_TIMING_CHECK, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_MONITOR_STATUS: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    // reading the monitor status samples it and so clears the accumulator
    assign sampleRead = arvalid && arready && araddr == ADDR_MONITOR_STATUS;
    assign clearAcc = dataRxStart || sampleRead; // [R5]
    assign accBase = clearAcc ? 6'h00 : st.errAccum;

    // ==================================================================
    // next state
    always_comb
    begin
        next_st = st;
        next_st.timeoutPulse = 1'b0;

        // write address and data are taken in either order
        if (awvalid && awready)
        begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_st.wHeld = 1'b1;
            next_st.wData = wdata[7:0];
            next_st.wLane = wstrb[0];
        end
        if (st.bValid && bready)
            next_st.bValid = 1'b0;
        if (doWrite)
        begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = wrHit ? RESP_OKAY : RESP_SLVERR;
        end

        // register writes; only byte lane 0 carries data, monitor status is read-only
        if (doWrite && st.wLane)
        begin
            unique case (st.awAddr)
                ADDR_MONITOR_SELECT:
                begin
                    next_st.monEnable = st.wData[MON_EN_LSB +: MON_EN_W]; // [R1]
                    next_st.accumulate = st.wData[MON_ACCU_BIT];
                end
                ADDR_WAKEUP_TIMEOUT: next_st.timeoutReg = st.wData;
                ADDR_SLICER_LOW: next_st.slicerLow = st.wData; // [R11]
                ADDR_SLICER_HIGH: next_st.slicerHigh = st.wData; // [R11]
                ADDR_TIMING_CHECK: next_st.timingCfg = st.wData[6:0]; // [R18]
                ADDR_IRQ_STATUS: next_st.irqStatus = st.irqStatus & ~st.wData[IRQ_W-1:0];
                ADDR_IRQ_MASK: next_st.irqMask = st.wData[IRQ_W-1:0];
                default: next_st.irqMask = next_st.irqMask;
            endcase
        end

        // read channel: data sampled on the address handshake
        if (st.rValid && rready)
            next_st.rValid = 1'b0;
        if (arvalid && arready)
        begin
            next_st.rValid = 1'b1;
            next_st.rData = rdMux;
            next_st.rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
        end

        // error accumulation; an error in the clearing cycle survives
        if (st.accumulate)
            next_st.errAccum = accBase | errs; // [R4]
        else
            next_st.errAccum = errs;

        // wakeup search timeout timer
        unique case (st.timerState)
            TIMER_IDLE:
            begin
                if (wakeupSearchStart && toCount != 6'h00) // [R7]
                begin
                    next_st.timerState = TIMER_RUN;
                    next_st.prescCount = 6'h00;
                    next_st.tickCount = 6'h00;
                end
            end
            TIMER_RUN:
            begin
                if (!wakeupSearchActive || toCount == 6'h00) // [R7]
                    next_st.timerState = TIMER_IDLE;
                else if (wakeupSearchStart)
                begin
                    next_st.prescCount = 6'h00;
                    next_st.tickCount = 6'h00;
                end
                else if (bitTick)
                begin
                    if ({1'b0, st.prescCount} == tickDiv - 7'h01) // [R8]
                    begin
                        next_st.prescCount = 6'h00;
                        next_st.tickCount = st.tickCount + 6'h01;
                        if (st.tickCount + 6'h01 == toCount) // [R6]
                        begin
                            next_st.timeoutPulse = 1'b1;
                            next_st.timerState = TIMER_IDLE;
                        end
                    end
                    else
                        next_st.prescCount = st.prescCount + 6'h01;
                end
            end
        endcase

        // hardware events come last so a set beats a clear in the same cycle
        if (slicerAcquireValid)
        begin
            next_st.slicerLow = slicerAcquired[7:0]; // [R9]
            next_st.slicerHigh = slicerAcquired[15:8]; // [R10]
            next_st.irqStatus[IRQ_SLICER] = 1'b1;
        end
        if (|errs)
            next_st.irqStatus[IRQ_EOF] = 1'b1; // [R3]
        if (st.timeoutPulse)
            next_st.irqStatus[IRQ_TIMEOUT] = 1'b1;
    end

    // state register
    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            st <= '0;
            st.monEnable <= RST_MONITOR_SELECT[MON_EN_LSB +: MON_EN_W];
            st.accumulate <= RST_MONITOR_SELECT[MON_ACCU_BIT];
            st.timeoutReg <= RST_WAKEUP_TIMEOUT;
            st.slicerLow <= RST_SLICER_LOW;
            st.slicerHigh <= RST_SLICER_HIGH;
            st.timingCfg <= RST_TIMING_CHECK;
            st.irqMask <= RST_IRQ_MASK;
            st.timerState <= TIMER_IDLE;
        end
        else
            st <= next_st;
    end

    // ==================================================================
    // checks; helper counts bit periods of one timer run
    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            helperBits <= 13'h0000;
        else if (wakeupSearchStart)
            helperBits <= 13'h0000;
        else if (st.timerState == TIMER_RUN && wakeupSearchActive && bitTick)
            helperBits <= helperBits + 13'h0001;
    end

    a_timeout_length: assert property (@(posedge clk) disable iff (!rstSync_n) // [R6]
        st.timeoutPulse |-> helperBits == 13'(toCount) * 13'(tickDiv))
        else $error("timeout length differs from count times tick");

    a_zero_disables: assert property (@(posedge clk) disable iff (!rstSync_n) // [R7]
        toCount == 6'h00 |=> !wakeupTimeout)
        else $error("timeout fired with zero count");

    a_monitor_gating: assert property (@(posedge clk) disable iff (!rstSync_n) // [R1]
        !st.accumulate |=> (st.errAccum & ~$past(st.monEnable)) == 6'h00)
        else $error("disabled monitor reported an error");

    a_chip_timeout_bit: assert property (@(posedge clk) disable iff (!rstSync_n) // [R2]
        dataRxActive && chipTimeoutError && st.monEnable[5] |=> st.errAccum[5] ##0 endOfFrame)
        else $error("chip timeout not on top enable bit");

    a_eof_raised: assert property (@(posedge clk) disable iff (!rstSync_n) // [R3]
        |errs |=> endOfFrame)
        else $error("end of frame not raised on monitor error");

    a_accumulate_hold: assert property (@(posedge clk) disable iff (!rstSync_n) // [R4]
        st.accumulate && st.errAccum[0] && !clearAcc |=> st.errAccum[0])
        else $error("accumulated error lost");

    a_start_clears: assert property (@(posedge clk) disable iff (!rstSync_n) // [R5]
        dataRxStart && !dataRxActive |=> st.errAccum == 6'h00)
        else $error("accumulator not cleared at reception start");

    a_slicer_capture: assert property (@(posedge clk) disable iff (!rstSync_n) // [R9]
        slicerAcquireValid |=> slicerInitialThreshold == $past(slicerAcquired))
        else $error("acquired threshold not captured");

    a_slicer_restore: assert property (@(posedge clk) disable iff (!rstSync_n) // [R11]
        doWrite && st.wLane && st.awAddr == ADDR_SLICER_HIGH && !slicerAcquireValid
        |=> slicerInitialThreshold[15:8] == $past(st.wData))
        else $error("threshold restore write lost");

endmodule : signal_check_config_regs

// File: test/axi_host.sv
`timescale 1ns/1ps
// =====
// bus master in place of the host controller
module axi_host (
    input wire logic clk,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    output logic awvalid = 1'b0,
    output logic [7:0] awaddr = 8'h00,
    output logic wvalid = 1'b0,
    output logic [31:0] wdata = 32'h0,
    output logic [3:0] wstrb = 4'h1,
    output logic bready = 1'b0,
    output logic arvalid = 1'b0,
    output logic [7:0] araddr = 8'h00,
    output logic rready = 1'b0,
    output logic hung = 1'b0
);
    // address and data go together; each is dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk); // one edge between transfers, so no signal is assigned twice in a step
        awaddr <= a;
        wdata <= {24'h0, (a == 8'hC0 || a == 8'hD0) ? {1'b0, d[6:0]} : d};
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 99);
        bready <= 1'b0;
        r = bresp;
        if (n >= 99) hung <= 1'b1;
    endtask : wr
    // read waits for rvalid, never for a fixed count
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 99);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        if (n >= 99) hung <= 1'b1;
    endtask : rd
endmodule : axi_host

// File: test/signal_check_config_regs_bench.sv
`timescale 1ns/1ps
module signal_check_config_regs_bench;
    logic clk = 1'b0, rst_n = 1'b0, dataRxActive = 1'b0, bitTick = 1'b0, ivl = 1'b0;
    logic wakeupSearchActive = 1'b0;
    logic [2:0] pls = 3'h0; // reception start, search start, slicer acquire
    logic [8:0] ie = 9'h000;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic irq, hung, endOfFrame, wakeupTimeout;
    logic [7:0] awaddr, araddr, d;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb, monErr = 4'h0;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] slicerAcquired = 16'h0, slicerInitialThreshold;
    logic [7:0] adr [8] = '{8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hD0, 8'hE0, 8'hE4, 8'hE8};
    logic [7:0] wv [5];
    logic [7:0] ens [7] = '{8'h41, 8'h11, 8'h05, 8'h03, 8'h01, 8'h21, 8'h21};
    logic [5:0] accs [7] = '{6'h20, 6'h08, 6'h02, 6'h01, 6'h00, 6'h10, 6'h00};
    int seed = 64929, n_fail = 0, compares = 0, ticks;
    // =====
    // 100 ns clock; one error line each for chip timeout, coding, RSSI and amplitude monitors
    always #50 clk = ~clk;
    signal_check_config_regs u_dut (.clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .dataRxStart(pls[0]), .dataRxActive, .bitTick, .chipTimeoutError(monErr[3]), .codingError(monErr[2]),
        .rssiError(monErr[1]), .amplitudeError(monErr[0]), .intervalValid(ivl), .intervalError(ie),
        .wakeupSearchStart(pls[1]), .wakeupSearchActive, .slicerAcquireValid(pls[2]), .slicerAcquired, .endOfFrame,
        .wakeupTimeout, .slicerInitialThreshold, .irq);
    axi_host u_host (.clk, .awready, .wready, .bvalid, .bresp, .arready, .rvalid, .rdata, .rresp, .awvalid,
        .awaddr, .wvalid, .wdata, .wstrb, .bready, .arvalid, .araddr, .rready, .hung);
    function automatic int tick_len(input int p);
        return (p == 0) ? 2 : (p == 1) ? 4 : (p == 2) ? 16 : 64;
    endfunction : tick_len
    function automatic int sgl_lim(input int c);
        return (c == 0) ? 16 : (c == 1) ? 24 : (c == 2) ? 32 : 48;
    endfunction : sgl_lim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic summarize();
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        u_host.rd(a, got, resp);
        chk(got, e);
        chk({30'h0, resp}, {30'h0, er});
    endtask : rdchk
    task automatic pulse(input int b);
        @(posedge clk);
        pls <= 3'(1 << b);
        @(posedge clk);
        pls <= 3'h0;
    endtask : pulse
    // a hung handshake counts as a mismatch and ends the run
    always @(posedge hung)
    begin
        n_fail++;
        summarize();
    end
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (adr[i]) rdchk(adr[i], 32'h0, 2'h0);
        rdchk(8'hFC, 32'h0, 2'h2);
        for (int i = 0; i < 5; i++)
        begin
            d = 8'($random(seed));
            u_host.wr(adr[i], d, resp);
            wv[i] = (i == 0 || i == 4) ? (d & 8'h7F) : d;
            rdchk(adr[i], {24'h0, wv[i]}, 2'h0);
        end
        chk({16'h0, slicerInitialThreshold}, {16'h0, wv[3], wv[2]});
        slicerAcquired <= 16'($random(seed));
        pulse(2);
        rdchk(8'hC8, {24'h0, slicerAcquired[7:0]}, 2'h0);
        rdchk(8'hCC, {24'h0, slicerAcquired[15:8]}, 2'h0);
        u_host.wr(8'hE4, 8'h04, resp);
        chk({31'h0, irq}, 32'h1);
        u_host.wr(8'hE0, 8'h04, resp);
        chk({31'h0, irq}, 32'h0);
        // all error lines fire; only the enabled monitor may count
        // last two runs: one interval at the single limit, then one just below it
        for (int k = 0; k < 7; k++)
        begin
            u_host.wr(8'hC0, ens[k], resp);
            pulse(0);
            dataRxActive <= 1'b1;
            ie <= 9'(sgl_lim(wv[4][1:0]) + 5 - k);
            @(posedge clk);
            monErr <= 4'hF;
            ivl <= 1'b1;
            @(posedge clk);
            monErr <= 4'h0;
            ivl <= 1'b0;
            @(posedge clk); // interval verdict comes one cycle late, so reception stays on
            dataRxActive <= 1'b0;
            rdchk(8'hE8, {26'h0, accs[k]}, 2'h0);
            rdchk(8'hE8, 32'h0, 2'h0);
            chk({31'h0, endOfFrame}, {31'h0, k < 4 || k == 5});
            u_host.wr(8'hE0, 8'h01, resp);
        end
        // count p+1 at prescaler p, then count zero which never expires
        wakeupSearchActive <= 1'b1;
        for (int p = 0; p < 5; p++)
        begin
            u_host.wr(8'hC4, (p < 4) ? {p[1:0], 6'(p + 1)} : 8'h00, resp);
            pulse(1);
            ticks = 0;
            got = 32'h0;
            for (int n = 0; n < 600 && got == 32'h0; n++)
            begin
                @(posedge clk);
                if (wakeupTimeout === 1'b1) got = 32'(ticks);
                bitTick <= n[0] && got == 32'h0 && n < 599;
                ticks += n[0];
            end
            chk(got, (p < 4) ? 32'((p + 1) * tick_len(p)) : 32'h0);
        end
        summarize();
    end
endmodule : signal_check_config_regs_bench
